// ### hw/pfo_regs.svh
// Register offsets, field positions and reset values of the fault and override block.
// Assumes an 8-bit AXI4-Lite byte address, one aligned 32-bit word per register.
`ifndef PFO_REGS_SVH
`define PFO_REGS_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define PFO_OFS_CONTROL   8'h00
`define PFO_OFS_MODULUS   8'h04
`define PFO_OFS_DUTY      8'h08
`define PFO_OFS_FAULT_DISABLE_MAP    8'h0c
`define PFO_OFS_FCTRL     8'h10
`define PFO_OFS_FSTAT     8'h14
`define PFO_OFS_FACK      8'h18
`define PFO_OFS_MANOUT    8'h1c

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define PFO_CTRL_ENABLE   0
`define PFO_CTRL_CENTER   1
`define PFO_CTRL_COMPL    2
`define PFO_CTRL_RATE_LO  3
`define PFO_CTRL_DT_LO    8
`define PFO_MAN_OVR_BIT   7
`define PFO_ACK_DT_LO     4
`define PFO_RST_MODULUS   12'h010
`define PFO_RST_DUTY      12'h008
`define PFO_RESP_OKAY     2'b00
`define PFO_RESP_SLVERR   2'b10

`endif

// ### hw/pfo_pkg.sv
// Types shared by the fault and override block.
// Constants live in pfo_regs.svh; this package holds types only.
package pfo_pkg;

    typedef enum logic {PFO_UP, PFO_DOWN} pfo_dir_type;

    typedef struct packed {
        logic [7:0] dead;
        logic [1:0] rate;
        logic       compl_mode;
        logic       center;
        logic       enable;
    } pfo_ctrl_type;

endpackage : pfo_pkg

// ### hw/pfo_top.sv
// Fault protection, current-sense monitor and manual output override of a six-output PWM unit.
// Assumes an AXI4-Lite master on clk and asynchronous fault and sense pins.
`timescale 1ns/1ps
`include "pfo_regs.svh"

// Function
// - Each fault pin has a mode bit, 1 automatic, 0 manual handling.
// - Per-pin interrupt enable; 1 lets a fault raise the interrupt request.
// - Fault protection acts regardless of interrupt enable, using the disable map.
// - Status bit reads the present level of each fault pin.
// - Sticky fault flag sets shortly after a rising edge on its pin.
// - Flag stays set until software writes 1 to its acknowledge bit.
// - Acknowledge bits read 0; writing 0 changes no flag.
// - Acknowledge register also shows read-only current-sense monitor bits.
// - Monitor bits capture sense pin just before dead-time ends, paired per pins.
// - Override enable 1 routes manual bits to dead-time stage instead of generator.
// - Generator keeps counting while override is active.
// - Clearing override returns generator outputs at once, no boundary wait.
// - Even manual bits, and all bits in independent mode, give active/inactive.
// - Complementary mode odd bit 1 gives complement of even partner, 0 inactive.
// - Counter advances one tick per clock, no prescaling.
// - Center-aligned period counts up to modulus and down, twice modulus ticks.
// - Edge-aligned period counts up only, modulus ticks.
// - Reload rate code 01 loads new parameters every two periods.
// - Eight-bit disable map is write-once until reset.
// - Module enable clear stops generator and floats pins unless override set.
// - Reload rate codes 00..11 reload every 1, 2, 4, 8 periods.
module pfo_top
    import pfo_pkg::*;
(
    input  wire logic        clk,            // 125 MHz bus clock
    input  wire logic        rst,            // Synchronous reset, high
    input  wire logic        ce,             // Clock enable, freezes all state
    input  wire logic [7:0]  s_axi_awaddr,   // Write address
    input  wire logic        s_axi_awvalid,  // Write address valid
    output logic             s_axi_awready,  // Write address ready
    input  wire logic [31:0] s_axi_wdata,    // Write data
    input  wire logic [3:0]  s_axi_wstrb,    // Write strobes
    input  wire logic        s_axi_wvalid,   // Write data valid
    output logic             s_axi_wready,   // Write data ready
    output logic [1:0]       s_axi_bresp,    // Write response
    output logic             s_axi_bvalid,   // Write response valid
    input  wire logic        s_axi_bready,   // Write response ready
    input  wire logic [7:0]  s_axi_araddr,   // Read address
    input  wire logic        s_axi_arvalid,  // Read address valid
    output logic             s_axi_arready,  // Read address ready
    output logic [31:0]      s_axi_rdata,    // Read data
    output logic [1:0]       s_axi_rresp,    // Read response
    output logic             s_axi_rvalid,   // Read data valid
    input  wire logic        s_axi_rready,   // Read data ready
    input  wire logic [3:0]  fault_pin,      // Fault inputs, high = fault
    input  wire logic [2:0]  current_sense,  // Sense pins a, b, c
    output logic [5:0]       pwm_out,        // PWM pin levels, high = active
    output logic [5:0]       pwm_oe,         // PWM pin drive enables
    output logic             irq             // Fault interrupt request
);

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    pfo_ctrl_type ctrl_q;
    logic [11:0]  mod_buf_q, duty_buf_q, mod_act_q, duty_act_q;
    logic [7:0]   map_q;
    logic         map_locked_q;
    logic [7:0]   fctrl_q;
    logic [7:0]   manout_q;
    logic [3:0]   flt_flag_q, flt_hold_q;
    logic [5:0]   sense_mon_q;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a[7:2] == ofs[7:2];
    endfunction : hit

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Three stages; a level counts once stages two and three agree.
    logic [6:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q;
    logic [6:0] pin_raw, pin_lvl_d;
    assign pin_raw = {current_sense, fault_pin};
    assign pin_lvl_d = (pin_s2_q & pin_s3_q) | (pin_lvl_q & (pin_s2_q | pin_s3_q));

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_s1_q  <= 7'h00;
            pin_s2_q  <= 7'h00;
            pin_s3_q  <= 7'h00;
            pin_lvl_q <= 7'h00;
        end else if (ce) begin
            pin_s1_q  <= pin_raw;
            pin_s2_q  <= pin_s1_q;
            pin_s3_q  <= pin_s2_q;
            pin_lvl_q <= pin_lvl_d;
        end
    end

    logic [3:0] flt_lvl, flt_rise, flt_auto, flt_ien;
    logic [2:0] sense_lvl;
    assign flt_lvl   = pin_lvl_q[3:0];
    assign sense_lvl = pin_lvl_q[6:4];
    assign flt_rise  = pin_lvl_d[3:0] & ~pin_lvl_q[3:0];

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    logic        aw_held_q, w_held_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        do_write, do_read, wr_known, rd_known, wlo;
    logic [31:0] rd_mux;

    assign s_axi_awready = ce & ~aw_held_q & ~s_axi_bvalid;
    assign s_axi_wready  = ce & ~w_held_q & ~s_axi_bvalid;
    assign s_axi_arready = ce & ~s_axi_rvalid;
    assign do_write = ce & aw_held_q & w_held_q & ~s_axi_bvalid;
    assign do_read  = s_axi_arvalid & s_axi_arready;
    assign wlo = do_write & w_strb_q[0];
    assign wr_known = aw_addr_q[7:5] == 3'b000;
    assign rd_known = s_axi_araddr[7:5] == 3'b000;

    // Flags are acknowledged only through byte lane 0.
    logic [3:0] ack_wr;
    assign ack_wr = (wlo && hit(aw_addr_q, `PFO_OFS_FACK)) ? w_data_q[3:0] : 4'h0;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr[4:2])
            3'd0:    rd_mux = {16'h0000, ctrl_q.dead, 3'b000, ctrl_q.rate, ctrl_q.compl_mode,
                               ctrl_q.center, ctrl_q.enable};
            3'd1:    rd_mux = {20'h00000, mod_buf_q};
            3'd2:    rd_mux = {20'h00000, duty_buf_q};
            3'd3:    rd_mux = {24'h000000, map_q};
            3'd4:    rd_mux = {24'h000000, fctrl_q};
            3'd5:    rd_mux = {24'h000000, flt_lvl[3], flt_flag_q[3], flt_lvl[2], flt_flag_q[2],
                               flt_lvl[1], flt_flag_q[1], flt_lvl[0], flt_flag_q[0]};
            3'd6:    rd_mux = {22'h000000, sense_mon_q, 4'h0};
            3'd7:    rd_mux = {24'h000000, manout_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            aw_addr_q    <= 8'h00;
            w_data_q     <= 32'h0000_0000;
            w_strb_q     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `PFO_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= `PFO_RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? `PFO_RESP_OKAY : `PFO_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_read) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_known ? rd_mux : 32'h0000_0000;
                s_axi_rresp  <= rd_known ? `PFO_RESP_OKAY : `PFO_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q       <= '0;
            mod_buf_q    <= `PFO_RST_MODULUS;
            duty_buf_q   <= `PFO_RST_DUTY;
            map_q        <= 8'h00;
            map_locked_q <= 1'b0;
            fctrl_q      <= 8'h00;
            manout_q     <= 8'h00;
        end else if (ce && wlo) begin
            if (hit(aw_addr_q, `PFO_OFS_CONTROL)) begin
                ctrl_q.enable     <= w_data_q[`PFO_CTRL_ENABLE];
                ctrl_q.center     <= w_data_q[`PFO_CTRL_CENTER];
                ctrl_q.compl_mode <= w_data_q[`PFO_CTRL_COMPL];
                ctrl_q.rate       <= w_data_q[`PFO_CTRL_RATE_LO +: 2];
                ctrl_q.dead       <= w_data_q[`PFO_CTRL_DT_LO +: 8];
            end
            if (hit(aw_addr_q, `PFO_OFS_MODULUS))
                mod_buf_q <= w_data_q[11:0];
            if (hit(aw_addr_q, `PFO_OFS_DUTY))
                duty_buf_q <= w_data_q[11:0];
            if (hit(aw_addr_q, `PFO_OFS_FAULT_DISABLE_MAP) && !map_locked_q) begin
                map_q        <= w_data_q[7:0];
                map_locked_q <= 1'b1;
            end
            if (hit(aw_addr_q, `PFO_OFS_FCTRL))
                fctrl_q <= w_data_q[7:0];
            if (hit(aw_addr_q, `PFO_OFS_MANOUT))
                manout_q <= w_data_q[7:0];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_fbits
            assign flt_auto[gi] = fctrl_q[2*gi];
            assign flt_ien[gi]  = fctrl_q[2*gi+1];
        end
    endgenerate

    // ----------------------------------------
    // PWM counter and reload
    // ----------------------------------------
    pfo_dir_type dir_q;
    logic [11:0] cnt_q;
    logic [2:0]  prd_cnt_q;
    logic [3:0]  rate_len;
    logic        boundary, reload;

    assign rate_len = 4'h1 << ctrl_q.rate;
    assign boundary = ctrl_q.enable &&
                      (ctrl_q.center ? (dir_q == PFO_DOWN && cnt_q <= 12'h001)
                                     : (cnt_q + 12'h001 >= mod_act_q));
    assign reload = boundary && ({1'b0, prd_cnt_q} + 4'h1 >= rate_len);

    always_ff @(posedge clk) begin
        if (rst) begin
            dir_q      <= PFO_UP;
            cnt_q      <= 12'h000;
            prd_cnt_q  <= 3'h0;
            mod_act_q  <= `PFO_RST_MODULUS;
            duty_act_q <= `PFO_RST_DUTY;
        end else if (ce) begin
            if (!ctrl_q.enable) begin
                // Stopped generator tracks the buffers so the first period uses fresh values.
                dir_q      <= PFO_UP;
                cnt_q      <= 12'h000;
                prd_cnt_q  <= 3'h0;
                mod_act_q  <= mod_buf_q;
                duty_act_q <= duty_buf_q;
            end else begin
                // Edge mode counts up only, even when switched over in mid-count.
                case (ctrl_q.center ? dir_q : PFO_UP)
                    PFO_UP: begin
                        if (!ctrl_q.center && cnt_q + 12'h001 >= mod_act_q) begin
                            cnt_q <= 12'h000;
                        end else begin
                            cnt_q <= cnt_q + 12'h001;
                            if (ctrl_q.center && cnt_q + 12'h001 >= mod_act_q)
                                dir_q <= PFO_DOWN;
                        end
                    end
                    PFO_DOWN: begin
                        cnt_q <= (cnt_q == 12'h000) ? 12'h000 : cnt_q - 12'h001;
                        if (cnt_q <= 12'h001)
                            dir_q <= PFO_UP;
                    end
                    default: dir_q <= PFO_UP;
                endcase
                if (boundary)
                    prd_cnt_q <= reload ? 3'h0 : prd_cnt_q + 3'h1;
                if (reload) begin
                    mod_act_q  <= mod_buf_q;
                    duty_act_q <= duty_buf_q;
                end
            end
        end
    end

    // ----------------------------------------
    // Faults
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            flt_flag_q <= 4'h0;
            flt_hold_q <= 4'h0;
        end else if (ce) begin
            // Set wins over a simultaneous acknowledge.
            flt_flag_q <= flt_rise | (flt_flag_q & ~ack_wr);
            for (int i = 0; i < 4; i++) begin
                if (flt_lvl[i])
                    flt_hold_q[i] <= 1'b1;
                else if (flt_auto[i] ? (boundary || !ctrl_q.enable) : !flt_flag_q[i])
                    flt_hold_q[i] <= 1'b0;
            end
        end
    end

    assign irq = |(flt_flag_q & flt_ien);

    // ----------------------------------------
    // Source select, dead-time and pins
    // ----------------------------------------
    logic       ovr;
    logic [5:0] gen_raw, man_raw, src, dt_out_q, pwm_q, kill;
    assign ovr = manout_q[`PFO_MAN_OVR_BIT];
    assign kill = (|flt_hold_q) ? map_q[5:0] : 6'h00;

    generate
        for (gi = 0; gi < 3; gi++) begin : g_pair
            logic       top_on;
            logic [7:0] dt_q;
            logic [1:0] dto_q, mon_q;
            assign dt_out_q[2*gi +: 2]    = dto_q;
            assign sense_mon_q[2*gi +: 2] = mon_q;
            assign top_on = cnt_q < duty_act_q;
            assign gen_raw[2*gi]   = top_on;
            assign gen_raw[2*gi+1] = ctrl_q.compl_mode ? ~top_on : top_on;
            assign man_raw[2*gi]   = manout_q[2*gi];
            assign man_raw[2*gi+1] = ctrl_q.compl_mode ? (manout_q[2*gi+1] & ~manout_q[2*gi])
                                                       : manout_q[2*gi+1];
            // Mux has no boundary wait, so clearing override takes effect next cycle.
            assign src[2*gi +: 2] = ovr ? man_raw[2*gi +: 2] : gen_raw[2*gi +: 2];

            always_ff @(posedge clk) begin
                if (rst) begin
                    dto_q <= 2'b00;
                    dt_q  <= 8'h00;
                    mon_q <= 2'b00;
                end else if (ce) begin
                    if (!ctrl_q.compl_mode) begin
                        dto_q <= src[2*gi +: 2];
                        dt_q  <= 8'h00;
                    end else if (src[2*gi +: 2] == dto_q) begin
                        dt_q <= ctrl_q.dead;
                    end else if (|(dto_q & ~src[2*gi +: 2])) begin
                        dto_q <= dto_q & src[2*gi +: 2];
                        dt_q  <= ctrl_q.dead;
                    end else if (dt_q != 8'h00) begin
                        dt_q <= dt_q - 8'h01;
                    end else begin
                        // Dead-time ends here: catch the sense level of the output turning on.
                        dto_q <= src[2*gi +: 2];
                        for (int j = 0; j < 2; j++)
                            if (src[2*gi+j] && !dto_q[j])
                                mon_q[j] <= sense_lvl[gi];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            pwm_q  <= 6'h00;
            pwm_oe <= 6'h00;
        end else if (ce) begin
            pwm_q  <= dt_out_q & ~kill;
            pwm_oe <= {6{ctrl_q.enable | ovr}};
        end
    end
    assign pwm_out = pwm_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    logic rd_ack_q;
    always_ff @(posedge clk) begin
        if (rst)
            rd_ack_q <= 1'b0;
        else if (do_read)
            rd_ack_q <= hit(s_axi_araddr, `PFO_OFS_FACK);
    end

    property p_flag_set;
        @(posedge clk) disable iff (rst) (ce && flt_rise[0]) |=> flt_flag_q[0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("fault flag not set after edge");

    property p_flag_hold;
        @(posedge clk) disable iff (rst) (flt_flag_q[1] && !ack_wr[1]) |=> flt_flag_q[1];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("fault flag lost without ack");

    property p_ack_zero;
        @(posedge clk) disable iff (rst) (s_axi_rvalid && rd_ack_q) |-> s_axi_rdata[3:0] == 4'h0;
    endproperty
    a_ack_zero: assert property (p_ack_zero) else $error("ack bits read nonzero");

    property p_irq;
        @(posedge clk) disable iff (rst) (ce && flt_rise[2] && flt_ien[2]) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("enabled fault raised no interrupt");

    property p_kill;
        @(posedge clk) disable iff (rst) (ce && flt_hold_q[0] && map_q[0]) |=> (!pwm_out[0] || !$past(ce));
    endproperty
    a_kill: assert property (p_kill) else $error("mapped pin driven during fault");

    property p_map_once;
        @(posedge clk) disable iff (rst) map_locked_q |=> (map_locked_q && $stable(map_q));
    endproperty
    a_map_once: assert property (p_map_once) else $error("disable map rewritten");

    property p_edge_wrap;
        @(posedge clk) disable iff (rst)
            (ce && ctrl_q.enable && !ctrl_q.center && cnt_q + 12'h001 == mod_act_q) |=> cnt_q == 12'h000;
    endproperty
    a_edge_wrap: assert property (p_edge_wrap) else $error("edge counter missed wrap");

    property p_center_turn;
        @(posedge clk) disable iff (rst)
            (ce && ctrl_q.enable && ctrl_q.center && dir_q == PFO_DOWN && cnt_q == 12'h001)
            |=> (cnt_q == 12'h000 && dir_q == PFO_UP);
    endproperty
    a_center_turn: assert property (p_center_turn) else $error("center counter missed turn");

    property p_ovr_runs;
        @(posedge clk) disable iff (rst)
            (ce && ovr && ctrl_q.enable && !ctrl_q.center && mod_act_q > 12'h001) |=> cnt_q != $past(cnt_q);
    endproperty
    a_ovr_runs: assert property (p_ovr_runs) else $error("counter stopped under override");

endmodule : pfo_top

// ### verif/pfo_plant.sv
// Plant model: fault sensors and current-sense comparators.
// Assumes the bench sets the wanted pin levels on clk.
`timescale 1ns/1ps
module pfo_plant (
    input  wire logic       clk,                 // Bench clock
    input  wire logic [3:0] fault_req,           // Wanted fault levels
    input  wire logic [2:0] sense_req,           // Wanted sense levels
    output logic      [3:0] fault_pin = 4'h0,    // Fault pins, high = fault
    output logic      [2:0] current_sense = 3'h0 // Sense comparators a, b, c
);
    // Skewed off the edge: real sensors know nothing of the bus clock
    always @(posedge clk) begin
        fault_pin     <= #3 fault_req;
        current_sense <= #3 sense_req;
    end
endmodule : pfo_plant

// ### verif/pfo_tb.sv
// Self-checking bench: register bus, fault flags, disable map, override.
// Assumes pfo_plant drives the pins; bus reads are scored from a queue.
`timescale 1ns/1ps
`include "pfo_regs.svh"
module pwm_fault_and_output_override_tb;
    localparam logic [31:0] M = 32'hffffffff;
    localparam logic [1:0]  OK = `PFO_RESP_OKAY;
    logic        clk = 0, rst = 1, ce = 1;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf, fault_req = 0, fault_pin;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, bq[$];
    logic [2:0]  sense_req = 0, current_sense;
    logic [5:0]  pwm_out, pwm_oe, e;
    logic [65:0] rq[$], n;
    logic [7:0]  v;
    int          err_total = 0, total_checks = 0;
    always #4 clk = ~clk;
    pfo_top dut (.clk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .fault_pin, .current_sense, .pwm_out, .pwm_oe, .irq);
    pfo_plant plant (.clk, .fault_req, .sense_req, .fault_pin, .current_sense);
    task automatic chk(input logic [33:0] g, input logic [33:0] x);
        total_checks++;
        if (g !== x) begin
            err_total++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        ta = 0;
        tw = 0;
        bq.push_back(OK);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ta && tw)) begin
            @(negedge clk);
            ta = ta | (s_axi_awvalid & s_axi_awready);
            tw = tw | (s_axi_wvalid & s_axi_wready);
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        @(negedge clk);
        while (!s_axi_bvalid) @(negedge clk);
        @(posedge clk);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic [1:0] r);
        rq.push_back({r, m, d});
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(negedge clk);
        while (!s_axi_arready) @(negedge clk);
        @(posedge clk);
        s_axi_arvalid <= 1'b0;
        @(negedge clk);
        while (!s_axi_rvalid) @(negedge clk);
        @(posedge clk);
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic per(input logic [33:0] x);
        time t;
        @(posedge pwm_out[0]);
        t = $time;
        @(posedge pwm_out[0]);
        chk(34'(($time - t) / 8), x);
    endtask : per
    // Handshakes are judged half a cycle before the edge that takes them
    always @(negedge clk) begin
        if (s_axi_bvalid && s_axi_bready) chk(34'(s_axi_bresp), 34'(bq.pop_front()));
        if (s_axi_rvalid && s_axi_rready) begin
            n = rq.pop_front();
            chk({s_axi_rresp, s_axi_rdata & n[63:32]}, {n[65:64], n[31:0] & n[63:32]});
        end
    end
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test
    initial begin
        #100us;
        err_total++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h9a60d140));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(`PFO_OFS_FCTRL, 0, M, OK);
        rd(`PFO_OFS_FACK, 0, 32'hfffffc0f, OK);
        rd(8'h20, 0, M, `PFO_RESP_SLVERR);
        v = 8'($urandom);
        wr(`PFO_OFS_FCTRL, {24'h0, v});
        rd(`PFO_OFS_FCTRL, {24'h0, v}, M, OK);
        for (int k = 0; k < 4; k++) begin
            wr(`PFO_OFS_FCTRL, 32'h2 << 2 * k);
            fault_req[k] <= 1'b1;
            repeat (6) @(posedge clk);
            chk(34'(irq), 34'h1);
            rd(`PFO_OFS_FSTAT, 32'h3 << 2 * k, M, OK);
            fault_req[k] <= 1'b0;
            wr(`PFO_OFS_FACK, 0);
            repeat (6) @(posedge clk);
            rd(`PFO_OFS_FSTAT, 32'h1 << 2 * k, M, OK);
            wr(`PFO_OFS_FACK, 32'h1 << k);
            rd(`PFO_OFS_FSTAT, 0, M, OK);
            chk(34'(irq), 34'h0);
        end
        wr(`PFO_OFS_FAULT_DISABLE_MAP, 32'h05);
        wr(`PFO_OFS_FAULT_DISABLE_MAP, 32'h3f);
        rd(`PFO_OFS_FAULT_DISABLE_MAP, 32'h05, M, OK);
        wr(`PFO_OFS_FCTRL, 0);
        wr(`PFO_OFS_MANOUT, 32'hbf);
        repeat (4) @(posedge clk);
        chk(34'(pwm_oe), 34'h3f);
        chk(34'(pwm_out), 34'h3f);
        fault_req[0] <= 1'b1;
        repeat (8) @(posedge clk);
        chk({irq, pwm_out}, 34'h3a);
        fault_req[0] <= 1'b0;
        repeat (8) @(posedge clk);
        chk(34'(pwm_out), 34'h3a);
        wr(`PFO_OFS_FACK, 32'h1);
        repeat (6) @(posedge clk);
        chk(34'(pwm_out), 34'h3f);
        wr(`PFO_OFS_CONTROL, 32'h4);
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'h3f : 8'($urandom);
            sense_req <= 3'($urandom);
            for (int p = 0; p < 3; p++) begin
                e[2 * p] = v[2 * p];
                e[2 * p + 1] = v[2 * p + 1] & ~v[2 * p];
            end
            wr(`PFO_OFS_MANOUT, {24'h0, 2'b10, v[5:0]});
            repeat (4) @(posedge clk);
            chk(34'(pwm_out), 34'(e));
        end
        v = 8'($urandom);
        sense_req <= v[2:0];
        wr(`PFO_OFS_MANOUT, 32'h80);
        wr(`PFO_OFS_MANOUT, 32'h95);
        rd(`PFO_OFS_FACK, {23'h0, v[2], 1'b0, v[1], 1'b0, v[0], 4'h0}, 32'hfffffd5f, OK);
        wr(`PFO_OFS_MANOUT, 0);
        repeat (4) @(posedge clk);
        chk(34'(pwm_oe), 34'h0);
        wr(`PFO_OFS_CONTROL, 32'h1);
        repeat (4) @(posedge clk);
        chk(34'(pwm_oe), 34'h3f);
        per(34'(`PFO_RST_MODULUS));
        wr(`PFO_OFS_CONTROL, 32'h3);
        per(34'(2 * `PFO_RST_MODULUS));
        wr(`PFO_OFS_CONTROL, 32'h9);
        wr(`PFO_OFS_MODULUS, 32'hc);
        repeat (40) @(posedge clk);
        per(34'hc);
        ce <= 1'b0;
        @(posedge clk);
        e = pwm_out;
        repeat (20) @(posedge clk);
        chk(34'(pwm_out), 34'(e));
        ce <= 1'b1;
        wr(`PFO_OFS_DUTY, 32'h3f);
        wr(`PFO_OFS_MANOUT, 32'h80);
        repeat (40) @(posedge clk);
        chk(34'(pwm_out), 34'h0);
        wr(`PFO_OFS_MANOUT, 0);
        repeat (2) @(posedge clk);
        chk(34'(pwm_out), 34'h3f);
        wr(`PFO_OFS_FCTRL, 32'h1);
        fault_req[0] <= 1'b1;
        repeat (8) @(posedge clk);
        chk({irq, pwm_out}, 34'h3a);
        fault_req[0] <= 1'b0;
        repeat (24) @(posedge clk);
        chk(34'(pwm_out), 34'h3f);
        stop_test();
    end
endmodule : pwm_fault_and_output_override_tb
